//--- shared/tsf_pkg.sv
// Constants and types shared by the thermal status flag bank
package tsf_pkg;
  // ****************************************************************
  // Bus addressing
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h4d;
  localparam logic [7:0] CMD_OVERTEMP = 8'h01;
  localparam logic [7:0] CMD_FAULT = 8'h02;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int OT_CH1_BIT = 0;
  localparam int OT_CH4_BIT = 3;
  localparam int OT_CH5_BIT = 4;
  localparam int OT_CH6_BIT = 5;
  localparam int FAULT_CH1_BIT = 1;
  localparam logic [5:0] TRIP_CHANNELS = 6'h39;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [5:0] CH_RESET = 6'h00;
  localparam logic [1:0] SYNC_IDLE_BUS = 2'h3;

  // ****************************************************************
  // Bus slave states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_CMD       = 4'h3,
    ST_CMD_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_READ      = 4'h7,
    ST_READ_ACK  = 4'h8
  } tsf_state_e;
endpackage : tsf_pkg

//--- logic/tsf_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module tsf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : tsf_sync

//--- logic/tsf_flag_bank.sv
// Thermal status flag bank with two-wire bus slave
//
// Contract
// [R01] Overtemperature bit 0 is set while channel 1 temperature exceeds its trip limit.
// [R02] Overtemperature bit 3 is set while channel 4 temperature exceeds its trip limit.
// [R03] Overtemperature bit 4 is set while channel 5 temperature exceeds its trip limit.
// [R04] Overtemperature bit 5 is set while channel 6 temperature exceeds its trip limit.
// [R05] The fault register holds channel n's fault flag at bit n for n from 1 to 6.
// [R06] A fault flag is set when the sensor inputs are open or the positive input is at supply.
// [R07] The device answers bus address 1001101 in bits 7 to 1, bit 0 giving the direction.
// [R08] A faulty channel is skipped by the measurement sequence.
// [R09] A masked channel cannot drive the thermal trip output.
// [R10] All flags clear at reset and reserved bits read as zero.
`timescale 1ns/1ps
module tsf_flag_bank #(
  parameter int CHANNELS = 6,
  parameter int TEMP_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  input wire logic [CHANNELS*TEMP_W-1:0] remote_temp,
  input wire logic [CHANNELS*TEMP_W-1:0] trip_limit,
  input wire logic [CHANNELS-1:0] sensor_inputs_open,
  input wire logic [CHANNELS-1:0] sensor_positive_input_high,
  input wire logic [CHANNELS-1:0] trip_mask,
  output logic thermal_trip_pin_out,
  output logic thermal_trip_pin_oe,
  output logic [CHANNELS-1:0] channel_skip,
  output logic [7:0] overtemp_flags,
  output logic [7:0] sensor_fault_flags
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] bus_s;
  logic [2*CHANNELS-1:0] sense_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;

  tsf_sync #(.WIDTH(2), .INIT(tsf_pkg::SYNC_IDLE_BUS)) u_bus_sync (
    .clk(clk),
    .rst(rst),
    .d({smb_clk_in, smb_data_in}),
    .q(bus_s)
  );

  // Fault comparators are analog, hence the crossing
  tsf_sync #(.WIDTH(2*CHANNELS), .INIT('0)) u_sense_sync (
    .clk(clk),
    .rst(rst),
    .d({sensor_inputs_open, sensor_positive_input_high}),
    .q(sense_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic [CHANNELS-1:0] over_limit;
  logic [CHANNELS-1:0] fault_reg;
  logic [CHANNELS-1:0] fault_next;
  logic [CHANNELS-1:0] trip_reg;
  logic [CHANNELS-1:0] trip_next;
  logic trip_oe_reg;
  logic trip_oe_next;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_cmp
      assign over_limit[gi] = remote_temp[gi*TEMP_W +: TEMP_W] > trip_limit[gi*TEMP_W +: TEMP_W];
    end
  endgenerate

  // [R06] Open or supply-tied input
  assign fault_next = sense_s[2*CHANNELS-1:CHANNELS] | sense_s[CHANNELS-1:0];
  // [R08] Faulty channel keeps its last result
  // [R01] [R02] [R03] [R04] Trip channels only
  assign trip_next = ((trip_reg & fault_reg) | (over_limit & ~fault_reg)) & tsf_pkg::TRIP_CHANNELS;
  // [R09] Masked channels cannot trip
  assign trip_oe_next = |(trip_reg & ~trip_mask);

  // [R10] Cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_reg <= tsf_pkg::CH_RESET;
      trip_reg <= tsf_pkg::CH_RESET;
      trip_oe_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      trip_reg <= trip_next;
      trip_oe_reg <= trip_oe_next;
    end
  end

  // Channel n sits at bit n-1 of the trip vector, matching the register
  // [R10] Reserved bits tied low
  assign overtemp_flags = {2'h0, trip_reg};
  // [R05] Channel n at bit n
  assign sensor_fault_flags = {1'b0, fault_reg, 1'b0};
  assign channel_skip = fault_reg;
  assign thermal_trip_pin_out = 1'b0;
  assign thermal_trip_pin_oe = trip_oe_reg;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  tsf_pkg::tsf_state_e state_reg;
  tsf_pkg::tsf_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic oe_reg;
  logic oe_next;
  logic rw_reg;
  logic rw_next;
  logic mack_reg;
  logic mack_next;
  logic [7:0] read_data;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic addr_match;
  logic byte_end;

  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign byte_end = scl_fall & (cnt_reg == tsf_pkg::BITS_PER_BYTE);
  // [R07] Seven-bit address match
  assign addr_match = shift_reg[7:1] == tsf_pkg::SLAVE_ADDR;
  // Unmapped commands read a fixed zero rather than stalling the bus
  assign read_data = (ptr_reg == tsf_pkg::CMD_OVERTEMP) ? overtemp_flags :
                     (ptr_reg == tsf_pkg::CMD_FAULT) ? sensor_fault_flags :
                     tsf_pkg::UNMAPPED_DATA;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    if (start_det) begin
      state_next = tsf_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      state_next = tsf_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        tsf_pkg::ST_ADDR, tsf_pkg::ST_CMD, tsf_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_end) begin
            cnt_next = 4'h0;
            oe_next = 1'b1;
            if (state_reg == tsf_pkg::ST_ADDR) begin
              // [R07] Ack own address, latch direction
              if (addr_match) begin
                state_next = tsf_pkg::ST_ADDR_ACK;
                rw_next = shift_reg[0];
              end else begin
                state_next = tsf_pkg::ST_IDLE;
                oe_next = 1'b0;
              end
            end else if (state_reg == tsf_pkg::ST_CMD) begin
              ptr_next = shift_reg;
              state_next = tsf_pkg::ST_CMD_ACK;
            end else begin
              // Written data is acknowledged and dropped: flags are read-only
              state_next = tsf_pkg::ST_WDATA_ACK;
            end
          end
        end
        tsf_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              state_next = tsf_pkg::ST_READ;
              tx_next = read_data;
              oe_next = ~read_data[7];
            end else begin
              state_next = tsf_pkg::ST_CMD;
              oe_next = 1'b0;
            end
          end
        end
        tsf_pkg::ST_CMD_ACK, tsf_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            state_next = tsf_pkg::ST_WDATA;
            oe_next = 1'b0;
          end
        end
        tsf_pkg::ST_READ: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_end) begin
            cnt_next = 4'h0;
            state_next = tsf_pkg::ST_READ_ACK;
            oe_next = 1'b0;
          end else if (scl_fall) begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = ~tx_reg[6];
          end
        end
        tsf_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              state_next = tsf_pkg::ST_READ;
              tx_next = read_data;
              oe_next = ~read_data[7];
            end else begin
              state_next = tsf_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_next = tsf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= tsf_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Open-drain: only ever pulls low
  assign smb_data_out = 1'b0;
  assign smb_data_oe = oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addr_hit;
    state_reg == tsf_pkg::ST_ADDR && byte_end && !start_det && !stop_det && addr_match;
  endsequence

  sequence s_addr_miss;
    state_reg == tsf_pkg::ST_ADDR && byte_end && !start_det && !stop_det && !addr_match;
  endsequence

  ch1_trip_a: assert property ( // [R01]
    !fault_reg[0] && over_limit[0] |=> overtemp_flags[tsf_pkg::OT_CH1_BIT])
    else $error("channel 1 trip flag not set");
  ch4_trip_a: assert property ( // [R02]
    !fault_reg[3] && !over_limit[3] |=> !overtemp_flags[tsf_pkg::OT_CH4_BIT])
    else $error("channel 4 trip flag set without cause");
  ch5_trip_a: assert property ( // [R03]
    !fault_reg[4] && over_limit[4] |=> overtemp_flags[tsf_pkg::OT_CH5_BIT])
    else $error("channel 5 trip flag not set");
  ch6_trip_a: assert property ( // [R04]
    !fault_reg[5] && over_limit[5] |=> overtemp_flags[tsf_pkg::OT_CH6_BIT])
    else $error("channel 6 trip flag not set");
  fault_open_a: assert property ( // [R05] [R06]
    sensor_inputs_open[1] [*4] |-> sensor_fault_flags[2])
    else $error("channel 2 open fault not flagged at bit 2");
  fault_supply_a: assert property ( // [R06]
    sensor_positive_input_high[5] [*4] |-> sensor_fault_flags[6])
    else $error("channel 6 supply fault not flagged");
  addr_ack_a: assert property ( // [R07]
    s_addr_hit |=> state_reg == tsf_pkg::ST_ADDR_ACK && smb_data_oe)
    else $error("own address not acknowledged");
  addr_ignore_a: assert property ( // [R07]
    s_addr_miss |=> state_reg == tsf_pkg::ST_IDLE && !smb_data_oe)
    else $error("foreign address acknowledged");
  skip_faulty_a: assert property ( // [R08]
    fault_reg[0] |=> $stable(overtemp_flags[tsf_pkg::OT_CH1_BIT]))
    else $error("faulty channel 1 still measured");
  trip_masked_a: assert property (trip_mask == 6'h3f |=> !thermal_trip_pin_oe) // [R09]
    else $error("masked channel drove thermal trip");
  flags_reset_a: assert property (@(posedge clk) disable iff (1'b0) // [R10]
    rst |=> overtemp_flags == tsf_pkg::FLAGS_RESET &&
    sensor_fault_flags == tsf_pkg::FLAGS_RESET)
    else $error("flags not cleared by reset");
  reserved_zero_a: assert property ( // [R10]
    overtemp_flags[7:6] == 2'h0 && overtemp_flags[2:1] == 2'h0 &&
    !sensor_fault_flags[7] && !sensor_fault_flags[0])
    else $error("reserved status bit reads nonzero");
endmodule : tsf_flag_bank

//--- tb/tsf_host_model.sv
// SMBus host model for the thermal status flag bank
`timescale 1ns/1ps
module tsf_host_model (
  input wire logic clk,
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // ****************************************************************
  // Bit timing
  // ****************************************************************
  // Ten-cycle high and fifteen-cycle low phases leave room for the device synchronisers
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic put_bit(input logic b);
    sda_oe = ~b;
    hold(10);
    scl = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_oe = 1'b0;
    hold(10);
    scl = 1'b1;
    hold(9);
    b = sda;
    hold(1);
    scl = 1'b0;
    hold(5);
  endtask : get_bit
  // Works from idle and as a repeated start
  task automatic start_cond();
    sda_oe = 1'b0;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_oe = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask : start_cond
  task automatic stop_cond();
    sda_oe = 1'b1;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_oe = 1'b0;
    hold(10);
  endtask : stop_cond
  // ****************************************************************
  // Transfers
  // ****************************************************************
  task automatic send_byte(input logic [7:0] v, output logic ok);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ok = ~b;
  endtask : send_byte
  // Read byte: no early exit on a missing ack, like a careless host
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd,
                          output logic [7:0] d, output logic acked);
    logic a1;
    logic a2;
    logic a3;
    start_cond();
    // address in bits 7 to 1, write direction in bit 0
    send_byte({addr, 1'b0}, a1);
    send_byte(cmd, a2);
    start_cond();
    send_byte({addr, 1'b1}, a3);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop_cond();
    acked = a1 & a2 & a3;
  endtask : read_reg
endmodule : tsf_host_model

//--- tb/thermal_status_flag_bank_tb.sv
// Self-checking testbench for the thermal status flag bank
`timescale 1ns/1ps
module thermal_status_flag_bank_tb;
  logic clk;
  logic rst;
  logic scl;
  logic host_oe;
  logic sda;
  logic smb_data_out;
  logic smb_data_oe;
  logic [47:0] remote_temp;
  logic [47:0] trip_limit;
  logic [5:0] sensor_inputs_open;
  logic [5:0] sensor_positive_input_high;
  logic [5:0] trip_mask;
  logic thermal_trip_pin_out;
  logic thermal_trip_pin_oe;
  logic [5:0] channel_skip;
  logic [7:0] overtemp_flags;
  logic [7:0] sensor_fault_flags;
  logic [7:0] ot_exp;
  logic [7:0] rd;
  logic ack;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 45;
  // Pull-up: high unless some party pulls low
  assign sda = ~(host_oe | smb_data_oe);
  tsf_flag_bank tsf_flag_bank_inst (.clk(clk), .rst(rst), .smb_clk_in(scl),
    .smb_data_in(sda), .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
    .remote_temp(remote_temp), .trip_limit(trip_limit),
    .sensor_inputs_open(sensor_inputs_open),
    .sensor_positive_input_high(sensor_positive_input_high), .trip_mask(trip_mask),
    .thermal_trip_pin_out(thermal_trip_pin_out), .thermal_trip_pin_oe(thermal_trip_pin_oe),
    .channel_skip(channel_skip), .overtemp_flags(overtemp_flags),
    .sensor_fault_flags(sensor_fault_flags));
  tsf_host_model tsf_host_model_inst (.clk(clk), .scl(scl), .sda_oe(host_oe), .sda(sda));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  function automatic logic [5:0] rnd6(input int k);
    logic [31:0] v;
    v = $random(seed);
    for (int i = 1; i < k; i++) v = v & $random(seed);
    return v[5:0];
  endfunction : rnd6
  function automatic logic [47:0] rnd48();
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[47:0];
  endfunction : rnd48
  // Faulty channels freeze; only channels 1, 4, 5 and 6 can trip
  function automatic logic [7:0] next_ot(input logic [7:0] old, input logic [5:0] flt);
    logic [7:0] r;
    logic [5:0] trip_ch;
    r = old;
    trip_ch = 6'h39;
    for (int n = 0; n < 6; n++)
      if (trip_ch[n] && !flt[n]) r[n] = remote_temp[8*n +: 8] > trip_limit[8*n +: 8];
    return r;
  endfunction : next_ot
  task automatic settle();
    logic [5:0] flt;
    flt = sensor_inputs_open | sensor_positive_input_high;
    ot_exp = next_ot(ot_exp, flt);
    // Fault clear reaches trip pin only after sync, flag, trip and pin stages
    step(6);
    check("overtemp_flags", ot_exp, overtemp_flags);
    check("sensor_fault_flags", {1'b0, flt, 1'b0}, sensor_fault_flags);
    check("channel_skip", {2'h0, flt}, {2'h0, channel_skip});
    check("trip_oe", {7'h0, |(ot_exp[5:0] & ~trip_mask)}, {7'h0, thermal_trip_pin_oe});
    check("trip_out", 8'h00, {7'h0, thermal_trip_pin_out});
  endtask : settle
  task automatic bus_read(input logic [7:0] cmd, input logic [7:0] exp);
    tsf_host_model_inst.read_reg(7'b1001101, cmd, rd, ack);
    check("bus_ack", 8'h01, {7'h0, ack});
    check("bus_data", exp, rd);
  endtask : bus_read
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("MISMATCH watchdog expected finish seen timeout");
    summarize();
  end
  initial begin
    rst = 1'b1;
    remote_temp = '0;
    trip_limit = '0;
    sensor_inputs_open = '0;
    sensor_positive_input_high = '0;
    trip_mask = '0;
    ot_exp = 8'h00;
    step(2);
    rst = 1'b0;
    settle();
    bus_read(tsf_pkg::CMD_OVERTEMP, 8'h00);
    bus_read(tsf_pkg::CMD_FAULT, 8'h00);
    for (int i = 0; i < 20; i++) begin
      sensor_inputs_open = rnd6(3);
      sensor_positive_input_high = rnd6(3);
      settle();
      remote_temp = rnd48();
      trip_limit = (i == 0) ? remote_temp : rnd48();
      trip_mask = rnd6(1);
      settle();
      if (i % 4 == 0) begin
        bus_read(tsf_pkg::CMD_OVERTEMP, ot_exp);
        bus_read(tsf_pkg::CMD_FAULT,
          {1'b0, sensor_inputs_open | sensor_positive_input_high, 1'b0});
      end
    end
    bus_read(8'h05, 8'h00);
    for (int b = 0; b < 7; b++) begin
      tsf_host_model_inst.read_reg(7'b1001101 ^ (7'h01 << b), 8'h01, rd, ack);
      check("foreign_addr_ack", 8'h00, {7'h0, ack});
    end
    // Reset in mid-run with trips and faults standing
    remote_temp = {6{8'hff}};
    trip_limit = '0;
    sensor_inputs_open = '0;
    sensor_positive_input_high = '0;
    // All channels masked: trips stand, pin stays quiet
    trip_mask = 6'h3f;
    settle();
    trip_mask = '0;
    sensor_inputs_open = 6'h3f;
    sensor_positive_input_high = 6'h20;
    settle();
    rst = 1'b1;
    step(2);
    check("rst_overtemp", 8'h00, overtemp_flags);
    check("rst_fault", 8'h00, sensor_fault_flags);
    check("rst_skip", 8'h00, {2'h0, channel_skip});
    check("rst_trip_oe", 8'h00, {7'h0, thermal_trip_pin_oe});
    check("rst_bus_oe", 8'h00, {7'h0, smb_data_oe});
    check("bus_out", 8'h00, {7'h0, smb_data_out});
    sensor_inputs_open = '0;
    sensor_positive_input_high = '0;
    ot_exp = 8'h00;
    rst = 1'b0;
    settle();
    bus_read(tsf_pkg::CMD_OVERTEMP, ot_exp);
    summarize();
  end
endmodule : thermal_status_flag_bank_tb
